// *** rtl/mtrr_regs.vh ***
// Constants for the memory type range resolver: fields, indices and codes.
`ifndef MTRR_REGS_VH
`define MTRR_REGS_VH

// Physical address width; 36 gives a 24-bit mask field, 40 gives 28 bits.
`define MTRR_PHYS_WIDTH 36
`define MTRR_FIELD_LSB 12
`define MTRR_PAIR_COUNT 8

// Register indices on the model-specific register port.
`define MTRR_IDX_WIDTH 5
`define MTRR_IDX_DEF_TYPE 5'h10

// Field positions.
`define MTRR_TYPE_MSB 7
`define MTRR_VALID_BIT 11
`define MTRR_FIXED_EN_BIT 10
`define MTRR_GLOBAL_EN_BIT 11

// Memory type encodings.
`define MTRR_TYPE_UC 8'h00
`define MTRR_TYPE_WC 8'h01
`define MTRR_TYPE_WT 8'h04
`define MTRR_TYPE_WP 8'h05
`define MTRR_TYPE_WB 8'h06

// Reset values.
`define MTRR_BASE_RESET 64'h0000000000000000
`define MTRR_MASK_RESET 64'h0000000000000000
`define MTRR_DEF_RESET 64'h0000000000000000

// Upper bound of the lowest megabyte: address bits 35..20 all zero.
`define MTRR_LOW_MB_LSB 20

`endif

// *** rtl/mtrr_range_resolver.v ***
// Memory type range resolver with variable base/mask pairs and precedence.
`timescale 1ns/1ps
`default_nettype none
`include "mtrr_regs.vh"

module mtrr_range_resolver (
	input wire core_clk,
	input wire rst,
	input wire clk_en,
	input wire reg_wr_en,
	input wire reg_rd_en,
	input wire [`MTRR_IDX_WIDTH-1:0] reg_index,
	input wire [63:0] reg_wdata,
	output reg [63:0] reg_rdata,
	output reg protection_fault,
	input wire [`MTRR_PHYS_WIDTH-1:0] lookup_addr,
	input wire [7:0] fixed_range_type,
	output reg [7:0] mem_type,
	output wire [`MTRR_PAIR_COUNT-1:0] range_hit
);

	localparam PW = `MTRR_PHYS_WIDTH;
	localparam NP = `MTRR_PAIR_COUNT;
	localparam LSB = `MTRR_FIELD_LSB;

	// Writable bits; everything else is reserved and faults on write.
	localparam [63:0] BASE_WMASK = ((64'h1 << PW) - 64'h1000) | 64'hFF;
	localparam [63:0] MASK_WMASK = ((64'h1 << PW) - 64'h1000) | 64'h800;
	localparam [63:0] DEF_WMASK = 64'h0000000000000CFF;

	reg [63:0] base_q [0:NP-1];
	reg [63:0] mask_q [0:NP-1];
	reg [63:0] def_q;

	// Legal memory type code check, used for the default type field.
	function legal_type;
		input [7:0] t;
		begin
			legal_type = (t == `MTRR_TYPE_UC) || (t == `MTRR_TYPE_WC) ||
				(t == `MTRR_TYPE_WT) || (t == `MTRR_TYPE_WP) ||
				(t == `MTRR_TYPE_WB);
		end
	endfunction

	// Index decode: even index is a base register, odd is a mask register.
	function [2:0] pair_of;
		input [`MTRR_IDX_WIDTH-1:0] idx;
		begin
			pair_of = idx[3:1];
		end
	endfunction

	wire idx_is_pair = (reg_index[4] == 1'b0);
	wire idx_is_def = (reg_index == `MTRR_IDX_DEF_TYPE);
	wire [2:0] wr_pair = pair_of(reg_index);
	wire idx_is_mask = reg_index[0];

	reg wr_bad;
	always @* begin
		wr_bad = 1'b1;
		if (idx_is_pair && !idx_is_mask) begin
			wr_bad = |(reg_wdata & ~BASE_WMASK);
		end else if (idx_is_pair && idx_is_mask) begin
			wr_bad = |(reg_wdata & ~MASK_WMASK);
		end else if (idx_is_def) begin
			wr_bad = (|(reg_wdata & ~DEF_WMASK)) ||
				!legal_type(reg_wdata[`MTRR_TYPE_MSB:0]);
		end
	end

	wire wr_ok = reg_wr_en && !wr_bad;

	// Pair registers; the valid bit clears at reset along with the rest.
	genvar g;
	generate
		for (g = 0; g < NP; g = g + 1) begin : pair_regs
			always @(posedge core_clk or posedge rst) begin
				if (rst) begin
					base_q[g] <= `MTRR_BASE_RESET;
					mask_q[g] <= `MTRR_MASK_RESET;
				end else if (clk_en && wr_ok && idx_is_pair &&
					wr_pair == g) begin
					if (idx_is_mask) begin
						mask_q[g] <= reg_wdata;
					end else begin
						base_q[g] <= reg_wdata;
					end
				end
			end
		end
	endgenerate

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			def_q <= `MTRR_DEF_RESET;
		end else if (clk_en && wr_ok && idx_is_def) begin
			def_q <= reg_wdata;
		end
	end

	// A rejected write leaves the register alone and pulses the fault.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			protection_fault <= 1'b0;
		end else if (clk_en) begin
			protection_fault <= reg_wr_en && wr_bad;
		end
	end

	// Reads of an unknown index return zero; only writes can fault.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 64'h0;
		end else if (clk_en && reg_rd_en) begin
			if (idx_is_pair && idx_is_mask) begin
				reg_rdata <= mask_q[wr_pair];
			end else if (idx_is_pair) begin
				reg_rdata <= base_q[wr_pair];
			end else if (idx_is_def) begin
				reg_rdata <= def_q;
			end else begin
				reg_rdata <= 64'h0;
			end
		end
	end

	// Parallel comparators, one per pair. Masks with holes match more
	// addresses, in scattered blocks; the rest fall through to the default type.
	generate
		for (g = 0; g < NP; g = g + 1) begin : cmp
			wire [PW-1:0] full_mask = {mask_q[g][PW-1:LSB],
				{LSB{1'b0}}};
			wire [PW-1:0] full_base = {base_q[g][PW-1:LSB],
				{LSB{1'b0}}};
			assign range_hit[g] = mask_q[g][`MTRR_VALID_BIT] &&
				((lookup_addr & full_mask) ==
				(full_base & full_mask));
		end
	endgenerate

	wire global_en = def_q[`MTRR_GLOBAL_EN_BIT];
	wire fixed_en = def_q[`MTRR_FIXED_EN_BIT];
	wire in_low_mb = ~|lookup_addr[PW-1:`MTRR_LOW_MB_LSB];

	reg [3:0] hits;
	reg any_uc;
	reg all_same;
	reg only_wt_wb;
	reg [7:0] first_t;
	reg [7:0] t;
	integer i;

	always @* begin
		hits = 4'h0;
		any_uc = 1'b0;
		all_same = 1'b1;
		only_wt_wb = 1'b1;
		first_t = 8'h00;
		t = 8'h00;
		// Walk from the top so first_t takes the highest matching pair.
		for (i = NP - 1; i >= 0; i = i - 1) begin
			if (range_hit[i]) begin
				t = base_q[i][`MTRR_TYPE_MSB:0];
				if (hits != 4'h0 && t != first_t) begin
					all_same = 1'b0;
				end
				if (hits == 4'h0) begin
					first_t = t;
				end
				if (t == `MTRR_TYPE_UC) begin
					any_uc = 1'b1;
				end
				if (t != `MTRR_TYPE_WT && t != `MTRR_TYPE_WB) begin
					only_wt_wb = 1'b0;
				end
				hits = hits + 4'h1;
			end
		end
		// Recheck sameness against the final highest pair type.
		for (i = 0; i < NP; i = i + 1) begin
			if (range_hit[i] &&
				base_q[i][`MTRR_TYPE_MSB:0] != first_t) begin
				all_same = 1'b0;
			end
		end
		if (!global_en) begin
			mem_type = `MTRR_TYPE_UC;
		end else if (fixed_en && in_low_mb) begin
			mem_type = fixed_range_type;
		end else if (hits == 4'h0) begin
			mem_type = def_q[`MTRR_TYPE_MSB:0];
		end else if (hits == 4'h1) begin
			mem_type = first_t;
		end else if (all_same) begin
			mem_type = first_t;
		end else if (any_uc) begin
			mem_type = `MTRR_TYPE_UC;
		end else if (only_wt_wb) begin
			mem_type = `MTRR_TYPE_WT;
		end else begin
			// Undefined overlap: take the highest-numbered pair's type.
			mem_type = first_t;
		end
	end

endmodule
`default_nettype wire

// *** bench/mtrr_check_sva.sv ***
// Port checker for the memory type range resolver.
`timescale 1ns/1ps
`default_nettype none
module mtrr_check (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [4:0] reg_index,
	input wire logic [63:0] reg_wdata,
	input wire logic [63:0] reg_rdata,
	input wire logic protection_fault,
	input wire logic [7:0] range_hit
);
	wire w = reg_wr_en & clk_en;
	wire [4:0] i = reg_index;
	wire [63:0] d = reg_wdata;
	wire msk = w & (i < 5'h10) & i[0];
	wire bas = w & (i < 5'h10) & ~i[0];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_bad_index: assert property (w && i > 5'h10 |=> protection_fault)
		else $error("unmapped write not refused");
	a_mask_low: assert property (msk && |d[10:0] |=> protection_fault)
		else $error("mask low bits accepted");
	a_mask_high: assert property (msk && |d[63:36] |=> protection_fault)
		else $error("mask high bits accepted");
	a_base_rsv: assert property (bas && (|d[11:8] || |d[63:36])
		|=> protection_fault) else $error("base reserved bits accepted");
	a_def_rsv: assert property (w && i == 5'h10
		&& (|d[9:8] || |d[63:12]) |=> protection_fault)
		else $error("default reserved bits accepted");
	a_mask_good: assert property (msk && d[10:0] == 11'h0
		&& d[63:36] == 28'h0 |=> !protection_fault)
		else $error("legal mask refused");
	a_fault_cause: assert property (protection_fault |-> $past(w))
		else $error("fault without write");
	a_read_unmap: assert property (reg_rd_en && clk_en && i > 5'h10
		|=> reg_rdata == 64'h0) else $error("unmapped read not zero");
	c_fault: cover property (protection_fault);
	c_def_wr: cover property (w && i == 5'h10);
	c_hit: cover property (|range_hit);
endmodule
bind mtrr_range_resolver mtrr_check mtrr_check_inst (.core_clk, .rst,
	.clk_en, .reg_wr_en, .reg_rd_en, .reg_index, .reg_wdata, .reg_rdata,
	.protection_fault, .range_hit);
`default_nettype wire

// *** bench/mtrr_core_model.sv ***
// Core access path model: lookup address and fixed range type.
`timescale 1ns/1ps
`default_nettype none
module mtrr_core_model (
	input wire logic [35:0] req_addr,
	output logic [35:0] lookup_addr,
	output logic [7:0] fixed_range_type
);
	// Above the low megabyte the fixed type is noise that must be ignored.
	assign lookup_addr = req_addr;
	assign fixed_range_type = (req_addr[35:20] == 16'h0) ? 8'h04 :
		~req_addr[19:12];
endmodule
`default_nettype wire

// *** bench/memory_type_range_resolver_test.sv ***
// Self-checking bench for the memory type range resolver.
`timescale 1ns/1ps
`default_nettype none
module memory_type_range_resolver_test;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic en = 1'b1;
	logic [4:0] idx = 5'h0;
	logic [63:0] wd = 64'h0, rdata;
	logic [35:0] req = 36'h0, la;
	logic [7:0] ft, mt, hit;
	logic fault;
	logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
	int fails = 0;
	int num_checks = 0;
	mtrr_core_model mtrr_core_model_inst (.req_addr(req),
		.lookup_addr(la), .fixed_range_type(ft));
	mtrr_range_resolver mtrr_range_resolver_inst (.core_clk(core_clk),
		.rst(rst), .clk_en(en), .reg_wr_en(wr), .reg_rd_en(rd),
		.reg_index(idx), .reg_wdata(wd), .reg_rdata(rdata),
		.protection_fault(fault), .lookup_addr(la),
		.fixed_range_type(ft), .mem_type(mt), .range_hit(hit));
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	task chk(input logic [63:0] s, input logic [63:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task put(input logic [4:0] i, input logic [63:0] d, input logic f);
		@(posedge core_clk);
		#1 wr = 1'b1;
		idx = i;
		wd = d;
		@(posedge core_clk);
		#1 wr = 1'b0;
		chk({63'h0, fault}, {63'h0, f});
	endtask
	task get(input logic [4:0] i, input logic [63:0] e);
		@(posedge core_clk);
		#1 rd = 1'b1;
		idx = i;
		@(posedge core_clk);
		#1 rd = 1'b0;
		chk(rdata, e);
	endtask
	task look(input logic [35:0] a, input logic [7:0] e);
		@(posedge core_clk);
		#1 req = a;
		#1 chk({56'h0, mt}, {56'h0, e});
	endtask
	task close_out;
		if (fails == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		#1 rst = 1'b0;
		look(36'h200000, 8'h00);
		put(5'h0, 64'h6, 1'b0);
		put(5'h1, 64'hFFC000800, 1'b0);
		put(5'h2, 64'hF00000, 1'b0);
		put(5'h3, 64'hFFFF00800, 1'b0);
		put(5'h4, 64'h2000004, 1'b0);
		put(5'h5, 64'hFFE000800, 1'b0);
		put(5'h6, 64'h6, 1'b0);
		put(5'h7, 64'hFFF000800, 1'b0);
		put(5'h8, 64'hA0000001, 1'b0);
		put(5'h9, 64'hFFF800800, 1'b0);
		put(5'hA, 64'hB0000006, 1'b0);
		put(5'hB, 64'hFFF800000, 1'b0);
		put(5'hE, 64'h100000006, 1'b0);
		put(5'hF, 64'hF00001800, 1'b0);
		put(5'h10, 64'hC05, 1'b0);
		look(36'h80000, 8'h04);
		look(36'h200000, 8'h06);
		look(36'hF80000, 8'h00);
		look(36'h2800000, 8'h04);
		look(36'hA0400000, 8'h01);
		look(36'hB0000000, 8'h05);
		look(36'h100000FFF, 8'h06);
		chk({56'h0, hit}, 64'h80);
		look(36'h100001000, 8'h05);
		put(5'h10, 64'h805, 1'b0);
		look(36'h80000, 8'h06);
		put(5'h1, 64'hFFC000801, 1'b1);
		put(5'h0, 64'h106, 1'b1);
		put(5'h3, 64'h1000FFFF00800, 1'b1);
		put(5'h10, 64'h906, 1'b1);
		put(5'h10, 64'h802, 1'b1);
		put(5'h11, 64'h0, 1'b1);
		get(5'h1, 64'hFFC000800);
		get(5'h10, 64'h805);
		get(5'h1F, 64'h0);
		for (int k = 0; k < 5; k++) begin
			put(5'h10, {56'h8, codes[k]}, 1'b0);
			look(36'h300000000, codes[k]);
		end
		// With the enable low a bad write must neither land nor fault.
		@(posedge core_clk);
		#1 en = 1'b0;
		put(5'h10, 64'h900, 1'b0);
		#1 en = 1'b1;
		get(5'h10, 64'h806);
		put(5'h10, 64'h6, 1'b0);
		look(36'h200000, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire
